// ### verilog/brd_top.sv
// Board reset distribution: sources, domain fan-out, AXI4-Lite registers
//
// Behaviour
// [R1] Power-on reset resets cpu, host bridge, PCI, ISA, and VMEbus when system controller.
// [R2] The reset switch resets all local domains and VMEbus only when system controller.
// [R3] The timekeeper watchdog resets all local domains and VMEbus when system controller.
// [R4] The second watchdog counts as a source only while the build option input is set.
// [R5] The alternate hot reset resets cpu, host bridge, PCI and ISA but not VMEbus.
// [R6] The PCI/ISA I/O reset resets only the PCI and ISA domains.
// [R7] Incoming VMEbus system reset resets all local domains and shows on the VMEbus domain.
// [R8] The VME bridge system software reset resets only the cpu, and the VMEbus when system controller.
// [R9] VME bridge local software and CSR resets reset cpu, host bridge and ISA only.
// [R10] Any host bridge reset turns every PCI map decoder off; software re-enables them.
// [R11] Each domain output is the OR of its sources and holds while any of them is active.
`timescale 1ns/100ps
module brd_top #(
  parameter int POR_HOLD_CYC = brd_pkg::POR_HOLD_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic rst_switch_n,
  input wire logic tk_wdt1_rst_req,
  input wire logic tk_wdt2_rst_req,
  input wire logic wdt2_option_fitted,
  input wire logic sys_ctrl_strap,
  input wire logic alternate_hot_reset_request,
  input wire logic pci_isa_io_rst_req,
  input wire logic vme_sys_sw_rst,
  input wire logic vme_loc_sw_rst,
  input wire logic vme_csr_rst,
  input wire logic vme_sysreset_n_i,
  output logic vme_sysreset_n_o,
  output logic vme_sysreset_oe_n,
  output logic cpu_rst,
  output logic processor_host_bridge_rst,
  output logic pci_dev_rst,
  output logic isa_dev_rst,
  output logic vme_dom_rst,
  output logic [brd_pkg::MAP_W-1:0] pci_map_dec_en,
  input wire logic [brd_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [brd_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ------------------------------------------------------------
  // Types and state
  // ------------------------------------------------------------
  typedef enum logic [1:0] {W_IDLE = 2'h1, W_RESP = 2'h2} brd_wst_e;
  typedef enum logic [1:0] {R_IDLE = 2'h1, R_DATA = 2'h2} brd_rdst_e;

  typedef struct packed {
    logic [brd_pkg::NDOM-1:0] dom;
    logic oe_n;
    logic [brd_pkg::MAP_W-1:0] map_en;
    logic [brd_pkg::NSRC-1:0] cause;
    brd_wst_e wst;
    brd_rdst_e rdst;
    logic aw_have, w_have, awready, wready, bvalid, arready, rvalid;
    logic [brd_pkg::AXI_AW-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
  } brd_state_s;

  brd_state_s q, n;

  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------
  // Domains reached by a set of active sources
  function automatic logic [brd_pkg::NDOM-1:0] brd_dom(
    input logic [brd_pkg::NSRC-1:0] s
  );
    logic [brd_pkg::NDOM-1:0] r;
    r = '0;
    for (int i = 0; i < brd_pkg::NSRC; i++) begin
      if (s[i]) begin
        r = r | brd_pkg::SRC_MASK[i*brd_pkg::NDOM +: brd_pkg::NDOM];
      end
    end
    return r;
  endfunction

  // Word address match, byte lanes ignored
  function automatic logic brd_hit(
    input logic [brd_pkg::AXI_AW-1:0] a,
    input logic [brd_pkg::AXI_AW-1:0] r
  );
    return a[brd_pkg::AXI_AW-1:2] == r[brd_pkg::AXI_AW-1:2];
  endfunction

  // Byte enables widened to a bit mask
  function automatic logic [31:0] brd_bmask(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  // ------------------------------------------------------------
  // Input synchronisation
  // ------------------------------------------------------------
  logic s_sw, s_wdt1, s_wdt2, s_fit, s_sysctl, s_hot, s_pio, s_vmein, s_sys, s_loc, s_csr;
  logic [10:0] syn;

  // Active-low pins are inverted first so a sync reset of zero is idle
  brd_sync #(.W(11)) u_sync (
    .clk(clk), .rst(rst),
    .d({~rst_switch_n, tk_wdt1_rst_req, tk_wdt2_rst_req,
        wdt2_option_fitted, sys_ctrl_strap, alternate_hot_reset_request,
        pci_isa_io_rst_req, ~vme_sysreset_n_i, vme_sys_sw_rst,
        vme_loc_sw_rst, vme_csr_rst}),
    .q(syn)
  );
  assign {s_sw, s_wdt1, s_wdt2, s_fit, s_sysctl, s_hot, s_pio, s_vmein, s_sys,
          s_loc, s_csr} = syn;

  // ------------------------------------------------------------
  // Power-on hold and VMEbus readback holdoff
  // ------------------------------------------------------------
  logic por_act, hold_act;

  // Power-on keeps every local domain, and VMEbus as system controller, down for a while after rst drops
  brd_pulse #(.N(POR_HOLD_CYC), .ACT_RST(1'b1)) u_por (
    .clk(clk), .rst(rst), .trig(1'b0), .act(por_act)
  );

  // Our own drive echoes back on the pin; ignore it until it has settled
  brd_pulse #(.N(brd_pkg::VME_REL_CYC), .ACT_RST(1'b0)) u_hold (
    .clk(clk), .rst(rst), .trig(~q.oe_n), .act(hold_act)
  );

  // ------------------------------------------------------------
  // Source vector
  // ------------------------------------------------------------
  logic [brd_pkg::NSRC-1:0] src, src_own;
  logic [brd_pkg::NDOM-1:0] dom_all, dom_own;

  // Echo masking avoids the board latching its own system reset
  always_comb begin
    src = '0;
    src[brd_pkg::SRC_POR] = por_act; // R1
    src[brd_pkg::SRC_SW] = s_sw; // R2
    src[brd_pkg::SRC_WDT1] = s_wdt1; // R3
    src[brd_pkg::SRC_WDT2] = s_wdt2 & s_fit; // R4
    src[brd_pkg::SRC_HOT] = s_hot; // R5
    src[brd_pkg::SRC_PIO] = s_pio; // R6
    src[brd_pkg::SRC_VMEIN] = s_vmein & q.oe_n & ~hold_act; // R7
    src[brd_pkg::SRC_SYSSW] = s_sys; // R8
    src[brd_pkg::SRC_LOCSW] = s_loc; // R9
    src[brd_pkg::SRC_CSR] = s_csr; // R9
    src_own = src;
    src_own[brd_pkg::SRC_VMEIN] = 1'b0;
  end

  // Incoming system reset never feeds our own drive
  assign dom_all = brd_dom(src); // R11
  assign dom_own = brd_dom(src_own);

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic [31:0] dm;
    logic [brd_pkg::NSRC-1:0] clr;
    dm = brd_bmask(q.w_strb);
    clr = '0;
    n = q;

    // Domain outputs; VMEbus driven only as system controller
    n.dom = dom_all; // R11
    n.oe_n = ~(dom_own[brd_pkg::DOM_VME] & s_sysctl); // R1 R2 R3 R8
    n.dom[brd_pkg::DOM_VME] = ~n.oe_n | src[brd_pkg::SRC_VMEIN]; // R7

    // Address and data may arrive in either order
    if (s_axi_awvalid && q.awready) begin
      n.aw_have = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      n.w_have = 1'b1;
      n.w_data = s_axi_wdata;
      n.w_strb = s_axi_wstrb;
    end

    // Write sequencer
    case (q.wst)
      W_IDLE: begin
        if (q.aw_have && q.w_have) begin
          n.bresp = brd_pkg::RESP_OKAY;
          if (brd_hit(q.aw_addr, brd_pkg::ADDR_MAP_CTRL)) begin
            n.map_en = (q.map_en & ~dm[brd_pkg::MAP_W-1:0]) |
                       (q.w_data[brd_pkg::MAP_W-1:0] & dm[brd_pkg::MAP_W-1:0]);
          end else if (brd_hit(q.aw_addr, brd_pkg::ADDR_RST_CAUSE)) begin
            clr = q.w_data[brd_pkg::NSRC-1:0] & dm[brd_pkg::NSRC-1:0];
          end else if (!brd_hit(q.aw_addr, brd_pkg::ADDR_RST_STAT)) begin
            n.bresp = brd_pkg::RESP_SLVERR;
          end
          n.aw_have = 1'b0;
          n.w_have = 1'b0;
          n.bvalid = 1'b1;
          n.wst = W_RESP;
        end
      end
      W_RESP: begin
        if (s_axi_bready) begin
          n.bvalid = 1'b0;
          n.wst = W_IDLE;
        end
      end
      default: begin
        n.wst = W_IDLE;
      end
    endcase
    n.awready = !n.aw_have && (n.wst == W_IDLE);
    n.wready = !n.w_have && (n.wst == W_IDLE);

    // Decoders stay off while the host bridge is held in reset
    if (q.dom[brd_pkg::DOM_HOSTBR]) begin
      n.map_en = '0; // R10
    end

    // Sticky cause bits: a new event beats a same-cycle clear
    n.cause = (q.cause & ~clr) | src;

    // Read sequencer; data is captured once and held
    case (q.rdst)
      R_IDLE: begin
        if (s_axi_arvalid && q.arready) begin
          n.rdata = '0;
          n.rresp = brd_pkg::RESP_OKAY;
          if (brd_hit(s_axi_araddr, brd_pkg::ADDR_MAP_CTRL)) begin
            n.rdata[brd_pkg::MAP_W-1:0] = q.map_en;
          end else if (brd_hit(s_axi_araddr, brd_pkg::ADDR_RST_STAT)) begin
            n.rdata[brd_pkg::NDOM-1:0] = q.dom;
            n.rdata[brd_pkg::STAT_SYSCTL] = s_sysctl;
            n.rdata[brd_pkg::STAT_FIT] = s_fit;
            n.rdata[brd_pkg::STAT_DRV] = ~q.oe_n;
          end else if (brd_hit(s_axi_araddr, brd_pkg::ADDR_RST_CAUSE)) begin
            n.rdata[brd_pkg::NSRC-1:0] = q.cause;
          end else begin
            n.rresp = brd_pkg::RESP_SLVERR;
          end
          n.rvalid = 1'b1;
          n.rdst = R_DATA;
        end
      end
      R_DATA: begin
        if (s_axi_rready) begin
          n.rvalid = 1'b0;
          n.rdst = R_IDLE;
        end
      end
      default: begin
        n.rdst = R_IDLE;
      end
    endcase
    n.arready = (n.rdst == R_IDLE);
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  // Local domains come up held; VMEbus is not driven until the strap is seen
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.dom <= brd_pkg::DOM_RST; // R1
      q.oe_n <= 1'b1;
      q.wst <= W_IDLE;
      q.rdst <= R_IDLE;
    end else begin
      q <= n;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Open drain: the level is low whenever the enable is active
  assign vme_sysreset_n_o = q.oe_n;
  assign vme_sysreset_oe_n = q.oe_n;
  assign cpu_rst = q.dom[brd_pkg::DOM_CPU];
  assign processor_host_bridge_rst = q.dom[brd_pkg::DOM_HOSTBR];
  assign pci_dev_rst = q.dom[brd_pkg::DOM_PCI];
  assign isa_dev_rst = q.dom[brd_pkg::DOM_ISA];
  assign vme_dom_rst = q.dom[brd_pkg::DOM_VME];
  assign pci_map_dec_en = q.map_en;
  assign {s_axi_awready, s_axi_wready, s_axi_arready} = {q.awready, q.wready, q.arready};
  assign {s_axi_bvalid, s_axi_bresp} = {q.bvalid, q.bresp};
  assign {s_axi_rvalid, s_axi_rresp, s_axi_rdata} = {q.rvalid, q.rresp, q.rdata};

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_locals_on;
    cpu_rst && processor_host_bridge_rst && pci_dev_rst && isa_dev_rst;
  endsequence

  sequence s_any_two;
    (|src) [*2];
  endsequence

  a_por_hold: assert property (por_act |=> s_locals_on) // R1
    else $error("power-on hold left a local domain free");
  a_por_vme: assert property (por_act && s_sysctl |=> !vme_sysreset_oe_n) // R1
    else $error("power-on did not drive VMEbus reset");
  a_switch_local: assert property (s_sw |=> s_locals_on) // R2
    else $error("reset switch missed a local domain");
  a_switch_vme: assert property (s_sw && s_sysctl |=> !vme_sysreset_oe_n) // R2
    else $error("reset switch did not drive VMEbus");
  a_no_ctrl_drive: assert property (!s_sysctl |=> vme_sysreset_oe_n) // R2
    else $error("VMEbus driven without system controller");
  a_wdt_reset: assert property (s_wdt1 |=> s_locals_on // R3
    and (vme_sysreset_oe_n == !$past(s_sysctl)))
    else $error("watchdog reset scope wrong");
  a_wdt2_fitted: assert property (s_wdt2 && s_fit |=> s_locals_on) // R4
    else $error("fitted second watchdog ignored");
  a_wdt2_gate: assert property (s_wdt2 && !s_fit && src[brd_pkg::SRC_WDT2-1:0] == '0 // R4
    && src[brd_pkg::NSRC-1:brd_pkg::SRC_WDT2+1] == '0 |=> !cpu_rst)
    else $error("unfitted second watchdog caused reset");
  a_hot_scope: assert property ($onehot(src) && src[brd_pkg::SRC_HOT] // R5
    |=> s_locals_on and vme_sysreset_oe_n)
    else $error("hot reset scope wrong");
  a_pio_scope: assert property ($onehot(src) && src[brd_pkg::SRC_PIO] // R6
    |=> pci_dev_rst && isa_dev_rst && !cpu_rst
    && !processor_host_bridge_rst && vme_sysreset_oe_n)
    else $error("PCI/ISA reset scope wrong");
  a_vmein_all: assert property (src[brd_pkg::SRC_VMEIN] // R7
    |=> s_locals_on and vme_dom_rst)
    else $error("incoming system reset not distributed");
  a_syssw_scope: assert property ($onehot(src) && src[brd_pkg::SRC_SYSSW] // R8
    |=> cpu_rst && !processor_host_bridge_rst && !pci_dev_rst
    && !isa_dev_rst && (vme_dom_rst == $past(s_sysctl)))
    else $error("system software reset scope wrong");
  a_locsw_scope: assert property ($onehot(src) // R9
    && (src[brd_pkg::SRC_LOCSW] || src[brd_pkg::SRC_CSR])
    |=> cpu_rst && processor_host_bridge_rst && isa_dev_rst
    && !pci_dev_rst && !vme_dom_rst)
    else $error("local or CSR reset scope wrong");
  a_map_clear: assert property (processor_host_bridge_rst // R10
    |=> pci_map_dec_en == '0)
    else $error("PCI map decoders left on across reset");
  a_or_hold: assert property (s_any_two |-> |q.dom) // R11
    else $error("domain released while a source is active");
  a_idle_release: assert property (src == '0 |=> q.dom == '0) // R11
    else $error("domain held with no source active");
endmodule

// ### verilog/brd_pkg.sv
// Shared constants of the board reset distribution block
package brd_pkg;
  // ------------------------------------------------------------
  // Reset domains, bit order {vme, isa, pci, host bridge, cpu}
  // ------------------------------------------------------------
  localparam int NDOM = 5;
  localparam int DOM_CPU = 0;
  localparam int DOM_HOSTBR = 1;
  localparam int DOM_PCI = 2;
  localparam int DOM_ISA = 3;
  localparam int DOM_VME = 4;
  localparam logic [NDOM-1:0] DOM_RST = 5'h0f;

  // ------------------------------------------------------------
  // Reset sources and the domains each one reaches
  // ------------------------------------------------------------
  localparam int NSRC = 10;
  localparam int SRC_POR = 0;
  localparam int SRC_SW = 1;
  localparam int SRC_WDT1 = 2;
  localparam int SRC_WDT2 = 3;
  localparam int SRC_HOT = 4;
  localparam int SRC_PIO = 5;
  localparam int SRC_VMEIN = 6;
  localparam int SRC_SYSSW = 7;
  localparam int SRC_LOCSW = 8;
  localparam int SRC_CSR = 9;
  // Highest source first
  localparam logic [NSRC*NDOM-1:0] SRC_MASK = {
    5'h0b, 5'h0b, 5'h11, 5'h1f, 5'h0c,
    5'h0f, 5'h1f, 5'h1f, 5'h1f, 5'h1f
  };

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam int AXI_AW = 8;
  localparam logic [AXI_AW-1:0] ADDR_MAP_CTRL = 8'h00;
  localparam logic [AXI_AW-1:0] ADDR_RST_STAT = 8'h04;
  localparam logic [AXI_AW-1:0] ADDR_RST_CAUSE = 8'h08;
  localparam int MAP_W = 4;
  localparam int STAT_SYSCTL = 8;
  localparam int STAT_FIT = 9;
  localparam int STAT_DRV = 10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_NS = 4;
  localparam int POR_HOLD_NS = 100000;
  localparam int VME_REL_NS = 200;
  localparam int POR_HOLD_CYC = (POR_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int VME_REL_CYC = (VME_REL_NS + CLK_NS - 1) / CLK_NS;
endpackage

// ### verilog/brd_sync.sv
// Two-stage synchroniser for asynchronous request pins
`timescale 1ns/100ps
module brd_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] safe;
  } brd_sync_s;
  brd_sync_s st_q;
  brd_sync_s st_d;

  // First stage feeds only the second stage
  always_comb begin
    st_d.meta = d;
    st_d.safe = st_q.meta;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.safe;
endmodule

// ### verilog/brd_pulse.sv
// Stretcher: holds its output while trig is high and N cycles beyond
`timescale 1ns/100ps
module brd_pulse #(
  parameter int N = 8,
  parameter bit ACT_RST = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic trig,
  output logic act
);
  localparam int CW = $clog2(N + 1);
  localparam logic [CW-1:0] LOAD = CW'(N);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic act;
  } brd_pulse_s;
  brd_pulse_s st_q;
  brd_pulse_s st_d;

  // Reload while triggered, else count down to zero
  always_comb begin
    st_d = st_q;
    if (trig) begin
      st_d.cnt = LOAD;
    end else if (st_q.cnt != '0) begin
      st_d.cnt = st_q.cnt - CW'(1);
    end
    st_d.act = trig | (st_d.cnt != '0);
  end

  // With ACT_RST the hold starts out full, so release begins the count
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q.cnt <= ACT_RST ? LOAD : '0;
      st_q.act <= ACT_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign act = st_q.act;
endmodule

// ### test/brd_far_model.sv
// Far side of the VMEbus reset line: backplane pull-up and other boards
`timescale 1ns/100ps
module brd_far_model (
  input wire logic oe_n,
  input wire logic ext_drive,
  output logic line_n
);
  // ------------------------------------------------------------
  // Open-collector wire
  // ------------------------------------------------------------
  // Pull-up wins only when nobody pulls low, so a released line reads 1
  always_comb begin
    line_n = (oe_n && !ext_drive) ? 1'b1 : 1'b0;
  end
endmodule

// ### test/test_board_reset_distribution.sv
// Self-checking bench for the board reset distribution block
`timescale 1ns/100ps
`define CHK(got, exp, msg) begin compares++; if ((got) !== (exp)) begin miscompares++; \
  $display("MISMATCH %0t: %s got %h exp %h", $time, msg, got, exp); end end
module test_board_reset_distribution;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic clk, rst, sw_n, wdt1, wdt2, fit, strap, hot, pio, syssw, locsw, csr, ext;
  logic line_n, vme_o, oe_n, cpu, hbr, pci, isa, vme;
  logic [3:0] map;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, r;
  int miscompares, compares, i;
  logic [10:0] rv [14];
  logic [4:0] re [14];

  brd_far_model brd_far_model_inst (.oe_n(oe_n), .ext_drive(ext), .line_n(line_n));
  brd_top #(.POR_HOLD_CYC(16)) brd_top_inst (
    .clk(clk), .rst(rst), .rst_switch_n(sw_n), .tk_wdt1_rst_req(wdt1),
    .tk_wdt2_rst_req(wdt2), .wdt2_option_fitted(fit), .sys_ctrl_strap(strap),
    .alternate_hot_reset_request(hot), .pci_isa_io_rst_req(pio),
    .vme_sys_sw_rst(syssw), .vme_loc_sw_rst(locsw), .vme_csr_rst(csr),
    .vme_sysreset_n_i(line_n), .vme_sysreset_n_o(vme_o), .vme_sysreset_oe_n(oe_n),
    .cpu_rst(cpu), .processor_host_bridge_rst(hbr), .pci_dev_rst(pci),
    .isa_dev_rst(isa), .vme_dom_rst(vme), .pci_map_dec_en(map),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // ------------------------------------------------------------
  // Clock
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Verdict in one place so a timeout ends the same way
  task automatic end_sim;
    $display("miscompares %0d compares %0d", miscompares, compares);
    if (miscompares == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Source vector: [10] strap, [9] option, [8:0] csr..switch
  task automatic apply(input logic [10:0] v);
    @(posedge clk);
    strap <= v[10];
    fit <= v[9];
    sw_n <= !v[0];
    wdt1 <= v[1];
    wdt2 <= v[2];
    hot <= v[3];
    pio <= v[4];
    ext <= v[5];
    syssw <= v[6];
    locsw <= v[7];
    csr <= v[8];
  endtask

  // AXI write: address and data offered together, each dropped when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] resp);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= dv;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    resp = bresp;
    bready <= 1'b0;
    if (n == 40) begin
      miscompares++;
      end_sim();
    end
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] resp);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    dv = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (n == 40) begin
      miscompares++;
      end_sim();
    end
  endtask

  // ------------------------------------------------------------
  // Rows: sources in, domains {vme,isa,pci,phb,cpu} out
  // ------------------------------------------------------------
  initial begin
    rv[0] = 11'h401; re[0] = 5'h1f;
    rv[1] = 11'h001; re[1] = 5'h0f;
    rv[2] = 11'h402; re[2] = 5'h1f;
    rv[3] = 11'h404; re[3] = 5'h00;
    rv[4] = 11'h604; re[4] = 5'h1f;
    rv[5] = 11'h408; re[5] = 5'h0f;
    rv[6] = 11'h410; re[6] = 5'h0c;
    rv[7] = 11'h420; re[7] = 5'h1f;
    rv[8] = 11'h440; re[8] = 5'h11;
    rv[9] = 11'h040; re[9] = 5'h01;
    rv[10] = 11'h480; re[10] = 5'h0b;
    rv[11] = 11'h500; re[11] = 5'h0b;
    rv[12] = 11'h418; re[12] = 5'h0f;
    rv[13] = 11'h5c0; re[13] = 5'h1b;
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    miscompares = 0;
    compares = 0;
    rst = 1'b1;
    {wdt1, wdt2, fit, hot, pio, syssw, locsw, csr, ext} = '0;
    sw_n = 1'b1;
    strap = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hf;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // Power-on hold reaches every domain, VMEbus as controller
    repeat (6) @(posedge clk);
    `CHK({vme, isa, pci, hbr, cpu}, 5'h1f, "power-on hold")
    repeat (80) @(posedge clk);
    `CHK({vme, isa, pci, hbr, cpu}, 5'h00, "power-on release")
    // Table of single and combined sources; 3 edges from pin to output
    for (i = 0; i < 14; i++) begin
      apply(rv[i]);
      repeat (6) @(posedge clk);
      `CHK({vme, isa, pci, hbr, cpu}, re[i], "domains")
      `CHK(oe_n, !(re[i][4] && !rv[i][5]), "vme drive")
      `CHK(vme_o, !(re[i][4] && !rv[i][5]), "vme level")
      apply(11'h400);
      repeat (70) @(posedge clk);
      `CHK({vme, isa, pci, hbr, cpu}, 5'h00, "release")
    end
    // Decoders survive a reset that spares the host bridge
    axw(8'h00, 32'h0000000f, r);
    axr(8'h00, d, r);
    `CHK(d, 32'h0000000f, "map readback")
    `CHK(map, 4'hf, "map enables")
    apply(11'h410);
    repeat (8) @(posedge clk);
    `CHK(map, 4'hf, "map kept on io reset")
    apply(11'h408);
    repeat (8) @(posedge clk);
    `CHK(map, 4'h0, "map cleared on hot reset")
    apply(11'h400);
    repeat (70) @(posedge clk);
    axr(8'h00, d, r);
    `CHK(d, 32'h00000000, "map after reset")
    // Byte lane 0 disabled: the decoder bits must not move
    wstrb <= 4'he;
    axw(8'h00, 32'h0000000f, r);
    `CHK(map, 4'h0, "masked byte lane")
    wstrb <= 4'hf;
    // Every source left its mark in the sticky cause register
    axr(8'h08, d, r);
    `CHK(d[9:0], 10'h3ff, "cause bits")
    axw(8'h08, 32'h000003ff, r);
    axr(8'h08, d, r);
    `CHK(d[9:0], 10'h000, "cause cleared")
    // Read-only write and unmapped read
    axw(8'h04, 32'hffffffff, r);
    `CHK(r, 2'h0, "status write resp")
    axr(8'h0c, d, r);
    `CHK(r, 2'h2, "unmapped resp")
    `CHK(d, 32'h00000000, "unmapped data")
    // Mid-run reset: locals held, VMEbus released, decoders and bus idle
    axw(8'h00, 32'h00000005, r);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK({vme, isa, pci, hbr, cpu}, 5'h0f, "held in reset")
    `CHK({oe_n, vme_o, map, awready}, 7'h60, "reset idle")
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK({vme, isa, pci, hbr, cpu}, 5'h1f, "power-on after reset")
    `CHK({oe_n, awready}, 2'h1, "driving and ready")
    end_sim();
  end
endmodule
